/* core/flag_bank_pkg.sv */
package flag_bank_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] AUX_WARN_OFS = 8'h53;
  localparam logic [ADDR_W-1:0] LINK_STAT_OFS = 8'h54;
  localparam logic [ADDR_W-1:0] OPTICS_FAULT_OFS = 8'h55;
  localparam logic [ADDR_W-1:0] SUPPLY_ALARM_OFS = 8'h56;
  localparam logic [ADDR_W-1:0] SUPPLY_WARN_OFS = 8'h57;
  // live (unlatched) mirrors of the five bytes, and the control byte
  localparam logic [ADDR_W-1:0] LIVE_AUX_OFS = 8'he0;
  localparam logic [ADDR_W-1:0] LIVE_LINK_OFS = 8'he1;
  localparam logic [ADDR_W-1:0] LIVE_OPTICS_OFS = 8'he2;
  localparam logic [ADDR_W-1:0] LIVE_ALARM_OFS = 8'he3;
  localparam logic [ADDR_W-1:0] LIVE_WARN_OFS = 8'he4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'hf0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AUX1_LOW_WARN_BIT = 4;
  localparam int AUX2_HIGH_WARN_BIT = 3;

  localparam int TX_NOT_READY_BIT = 7;
  localparam int LASER_FAULT_BIT = 6;
  localparam int TX_CDR_UNLOCK_BIT = 5;
  localparam int RX_NOT_READY_BIT = 4;
  localparam int RX_SIGNAL_LOSS_BIT = 3;
  localparam int RX_CDR_UNLOCK_BIT = 2;
  localparam int MODULE_NOT_READY_BIT = 1;
  localparam int RESET_COMPLETE_BIT = 0;

  localparam int PHOTODIODE_FAULT_BIT = 7;
  localparam int COOLER_FAULT_BIT = 6;
  localparam int WAVELENGTH_UNLOCK_BIT = 5;

  // supply bytes: high/low pairs, rails in this order from the top
  localparam int FIVE_HIGH_BIT = 7;
  localparam int FIVE_LOW_BIT = 6;
  localparam int THREE_HIGH_BIT = 5;
  localparam int THREE_LOW_BIT = 4;
  localparam int ONE_EIGHT_HIGH_BIT = 3;
  localparam int ONE_EIGHT_LOW_BIT = 2;
  localparam int NEG_FIVE_HIGH_BIT = 1;
  localparam int NEG_FIVE_LOW_BIT = 0;

  localparam int CTRL_CLEAR_ON_READ_BIT = 0;
  localparam int CTRL_CLEAR_ALL_BIT = 7;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] AUX_WARN_MASK = 8'h18;
  localparam logic [DATA_W-1:0] LINK_STAT_MASK = 8'hff;
  localparam logic [DATA_W-1:0] OPTICS_FAULT_MASK = 8'he0;
  localparam logic [DATA_W-1:0] SUPPLY_MASK = 8'hff;
  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01;
  localparam logic [DATA_W-1:0] CTRL_STORE_MASK = 8'h01;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

endpackage

/* core/flag_byte_if.sv */
`timescale 1ns/100ps
interface flag_byte_if #(
  parameter int W = 8
);
  logic [W-1:0] src;
  logic clr;
  logic [W-1:0] flags;

  modport latch (input src, input clr, output flags);
  modport bank (output src, output clr, input flags);
endinterface

/* core/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* core/latch_byte.sv */
`timescale 1ns/100ps
module latch_byte #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL_MASK = '1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  flag_byte_if.latch lb
);

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // a source high in the clear cycle keeps its flag, so no event is lost
  always_comb
  begin
    flags_nxt = flags_r;
    if (lb.clr)
    begin
      flags_nxt = '0;
    end
    flags_nxt = (flags_nxt | lb.src) & IMPL_MASK; // R13
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= RESET_VAL;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  assign lb.flags = flags_r;

endmodule

/* core/latched_module_flag_bank.sv */
// Functional notes
// R1 - Byte 0x54 latches transmit-not-ready in bit 7, laser fault in bit 6 and transmit clock-recovery unlock in bit 5.
// R2 - The laser fault latch is set from the fault output of the laser safety circuit.
// R3 - Bit 3 of byte 0x54 latches a copy of the receive signal-loss pin.
// R4 - Byte 0x54 latches receive-not-ready in bit 4 and receive clock-recovery unlock in bit 2.
// R5 - Bit 1 of byte 0x54 latches a copy of the module-not-ready pin.
// R6 - Bit 0 of byte 0x54 is set once the module has come out of reset.
// R7 - Byte 0x55 latches photodiode bias supply fault in bit 7 and cooler fault in bit 6.
// R8 - Bit 5 of byte 0x55 latches wavelength unlock and bits 4 to 0 read as zero.
// R9 - Byte 0x56 latches supply alarms as high/low pairs: 5 V, 3.3 V, 1.8 V, then -5.2 V from bit 7 down.
// R10 - Byte 0x57 latches supply warnings in the same rail order and pairing, 5 V high warning in bit 7.
// R11 - Bit 4 of byte 0x53 latches the low warning of the first auxiliary monitor.
// R12 - Bit 3 of byte 0x53 latches the high warning of the second auxiliary monitor.
// R13 - A latched flag stays set until the host reads its byte, which clears it; a clear-all write also clears it, and with clear-on-read off reads do not.
`timescale 1ns/100ps
module latched_module_flag_bank #(
  parameter int ADDR_W = flag_bank_pkg::ADDR_W,
  parameter int DATA_W = flag_bank_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // auxiliary monitor conditions
  input wire logic aux1_low_warn,
  input wire logic aux2_high_warn,
  // link status conditions
  input wire logic transmit_not_ready,
  input wire logic laser_fault,
  input wire logic tx_cdr_unlock,
  input wire logic receive_not_ready,
  input wire logic receive_signal_loss,
  input wire logic rx_cdr_unlock,
  input wire logic module_not_ready,
  // optics faults
  input wire logic avalanche_photodiode_fault,
  input wire logic thermoelectric_cooler_fault,
  input wire logic wavelength_unlocked,
  // supply monitor, high/low per rail
  input wire logic plus_five_volt_rail_alarm_high,
  input wire logic plus_five_volt_rail_alarm_low,
  input wire logic three_volt_rail_alarm_high,
  input wire logic three_volt_rail_alarm_low,
  input wire logic one_eight_volt_rail_alarm_high,
  input wire logic one_eight_volt_rail_alarm_low,
  input wire logic negative_five_volt_rail_alarm_high,
  input wire logic negative_five_volt_rail_alarm_low,
  input wire logic plus_five_volt_rail_warn_high,
  input wire logic plus_five_volt_rail_warn_low,
  input wire logic three_volt_rail_warn_high,
  input wire logic three_volt_rail_warn_low,
  input wire logic one_eight_volt_rail_warn_high,
  input wire logic one_eight_volt_rail_warn_low,
  input wire logic negative_five_volt_rail_warn_high,
  input wire logic negative_five_volt_rail_warn_low
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // raw condition bytes, arranged as the register layout
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] aux_raw;
  logic [DATA_W-1:0] link_raw;
  logic [DATA_W-1:0] optics_raw;
  logic [DATA_W-1:0] alarm_raw;
  logic [DATA_W-1:0] warn_raw;

  // auxiliary monitor warnings; the rest of the byte is outside this bank
  always_comb
  begin
    aux_raw = '0;
    aux_raw[flag_bank_pkg::AUX1_LOW_WARN_BIT] = aux1_low_warn; // R11
    aux_raw[flag_bank_pkg::AUX2_HIGH_WARN_BIT] = aux2_high_warn; // R12
  end

  // link status; the reset-complete bit is added after the synchroniser
  always_comb
  begin
    link_raw = '0;
    link_raw[flag_bank_pkg::TX_NOT_READY_BIT] = transmit_not_ready; // R1
    link_raw[flag_bank_pkg::LASER_FAULT_BIT] = laser_fault; // R2
    link_raw[flag_bank_pkg::TX_CDR_UNLOCK_BIT] = tx_cdr_unlock; // R1
    link_raw[flag_bank_pkg::RX_NOT_READY_BIT] = receive_not_ready; // R4
    link_raw[flag_bank_pkg::RX_SIGNAL_LOSS_BIT] = receive_signal_loss; // R3
    link_raw[flag_bank_pkg::RX_CDR_UNLOCK_BIT] = rx_cdr_unlock; // R4
    link_raw[flag_bank_pkg::MODULE_NOT_READY_BIT] = module_not_ready; // R5
  end

  // optics faults; low five bits stay zero
  always_comb
  begin
    optics_raw = '0;
    optics_raw[flag_bank_pkg::PHOTODIODE_FAULT_BIT] = avalanche_photodiode_fault; // R7
    optics_raw[flag_bank_pkg::COOLER_FAULT_BIT] = thermoelectric_cooler_fault; // R7
    optics_raw[flag_bank_pkg::WAVELENGTH_UNLOCK_BIT] = wavelength_unlocked; // R8
  end

  // supply alarms
  always_comb
  begin
    alarm_raw = '0;
    alarm_raw[flag_bank_pkg::FIVE_HIGH_BIT] = plus_five_volt_rail_alarm_high; // R9
    alarm_raw[flag_bank_pkg::FIVE_LOW_BIT] = plus_five_volt_rail_alarm_low; // R9
    alarm_raw[flag_bank_pkg::THREE_HIGH_BIT] = three_volt_rail_alarm_high; // R9
    alarm_raw[flag_bank_pkg::THREE_LOW_BIT] = three_volt_rail_alarm_low; // R9
    alarm_raw[flag_bank_pkg::ONE_EIGHT_HIGH_BIT] = one_eight_volt_rail_alarm_high; // R9
    alarm_raw[flag_bank_pkg::ONE_EIGHT_LOW_BIT] = one_eight_volt_rail_alarm_low; // R9
    alarm_raw[flag_bank_pkg::NEG_FIVE_HIGH_BIT] = negative_five_volt_rail_alarm_high; // R9
    alarm_raw[flag_bank_pkg::NEG_FIVE_LOW_BIT] = negative_five_volt_rail_alarm_low; // R9
  end

  // supply warnings, same pairing as the alarms
  always_comb
  begin
    warn_raw = '0;
    warn_raw[flag_bank_pkg::FIVE_HIGH_BIT] = plus_five_volt_rail_warn_high; // R10
    warn_raw[flag_bank_pkg::FIVE_LOW_BIT] = plus_five_volt_rail_warn_low; // R10
    warn_raw[flag_bank_pkg::THREE_HIGH_BIT] = three_volt_rail_warn_high; // R10
    warn_raw[flag_bank_pkg::THREE_LOW_BIT] = three_volt_rail_warn_low; // R10
    warn_raw[flag_bank_pkg::ONE_EIGHT_HIGH_BIT] = one_eight_volt_rail_warn_high; // R10
    warn_raw[flag_bank_pkg::ONE_EIGHT_LOW_BIT] = one_eight_volt_rail_warn_low; // R10
    warn_raw[flag_bank_pkg::NEG_FIVE_HIGH_BIT] = negative_five_volt_rail_warn_high; // R10
    warn_raw[flag_bank_pkg::NEG_FIVE_LOW_BIT] = negative_five_volt_rail_warn_low; // R10
  end

  // ----------------------------------------------------------------
  // synchronisers: every condition comes from pins or other logic
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] aux_live;
  logic [DATA_W-1:0] link_pins_live;
  logic [DATA_W-1:0] optics_live;
  logic [DATA_W-1:0] alarm_live;
  logic [DATA_W-1:0] warn_live;

  pin_sync #(.W(DATA_W)) u_sync_aux (
    .clk(clk),
    .rst(rst),
    .d(aux_raw),
    .q(aux_live)
  );

  pin_sync #(.W(DATA_W)) u_sync_link (
    .clk(clk),
    .rst(rst),
    .d(link_raw),
    .q(link_pins_live)
  );

  pin_sync #(.W(DATA_W)) u_sync_optics (
    .clk(clk),
    .rst(rst),
    .d(optics_raw),
    .q(optics_live)
  );

  pin_sync #(.W(DATA_W)) u_sync_alarm (
    .clk(clk),
    .rst(rst),
    .d(alarm_raw),
    .q(alarm_live)
  );

  pin_sync #(.W(DATA_W)) u_sync_warn (
    .clk(clk),
    .rst(rst),
    .d(warn_raw),
    .q(warn_live)
  );

  // ----------------------------------------------------------------
  // reset-complete event
  // ----------------------------------------------------------------
  logic out_of_reset_r;
  logic reset_done_pulse;
  logic [DATA_W-1:0] link_live;

  // one pulse at the first edge after release; later reads clear it for good
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_of_reset_r <= 1'b0;
    end
    else
    begin
      out_of_reset_r <= 1'b1;
    end
  end

  assign reset_done_pulse = ~out_of_reset_r; // R6

  always_comb
  begin
    link_live = link_pins_live;
    link_live[flag_bank_pkg::RESET_COMPLETE_BIT] = reset_done_pulse; // R6
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_r;
  logic clear_all;
  logic clear_on_read;

  // only the read-clear enable is stored; the clear-all bit is a strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= flag_bank_pkg::CTRL_RESET;
    end
    else if (wr && hit(addr, flag_bank_pkg::CTRL_OFS))
    begin
      ctrl_r <= wdata & flag_bank_pkg::CTRL_STORE_MASK;
    end
  end

  assign clear_on_read = ctrl_r[flag_bank_pkg::CTRL_CLEAR_ON_READ_BIT];
  assign clear_all = wr && hit(addr, flag_bank_pkg::CTRL_OFS) && wdata[flag_bank_pkg::CTRL_CLEAR_ALL_BIT];

  // ----------------------------------------------------------------
  // latched flag bytes
  // ----------------------------------------------------------------
  flag_byte_if #(.W(DATA_W)) aux_lb ();
  flag_byte_if #(.W(DATA_W)) link_lb ();
  flag_byte_if #(.W(DATA_W)) optics_lb ();
  flag_byte_if #(.W(DATA_W)) alarm_lb ();
  flag_byte_if #(.W(DATA_W)) warn_lb ();

  // a read clears its byte; with read-clear off, flags hold until clear-all
  assign aux_lb.src = aux_live;
  assign aux_lb.clr = clear_all || (rd && clear_on_read && hit(addr, flag_bank_pkg::AUX_WARN_OFS)); // R13
  assign link_lb.src = link_live;
  assign link_lb.clr = clear_all || (rd && clear_on_read && hit(addr, flag_bank_pkg::LINK_STAT_OFS)); // R13
  assign optics_lb.src = optics_live;
  assign optics_lb.clr = clear_all || (rd && clear_on_read && hit(addr, flag_bank_pkg::OPTICS_FAULT_OFS)); // R13
  assign alarm_lb.src = alarm_live;
  assign alarm_lb.clr = clear_all || (rd && clear_on_read && hit(addr, flag_bank_pkg::SUPPLY_ALARM_OFS)); // R13
  assign warn_lb.src = warn_live;
  assign warn_lb.clr = clear_all || (rd && clear_on_read && hit(addr, flag_bank_pkg::SUPPLY_WARN_OFS)); // R13

  latch_byte #(.W(DATA_W), .IMPL_MASK(flag_bank_pkg::AUX_WARN_MASK), .RESET_VAL(flag_bank_pkg::FLAG_RESET)) u_aux (
    .clk(clk),
    .rst(rst),
    .lb(aux_lb.latch)
  );

  latch_byte #(.W(DATA_W), .IMPL_MASK(flag_bank_pkg::LINK_STAT_MASK), .RESET_VAL(flag_bank_pkg::FLAG_RESET)) u_link (
    .clk(clk),
    .rst(rst),
    .lb(link_lb.latch)
  );

  // reserved low bits masked off so they always read zero
  latch_byte #(.W(DATA_W), .IMPL_MASK(flag_bank_pkg::OPTICS_FAULT_MASK), .RESET_VAL(flag_bank_pkg::FLAG_RESET)) u_optics (
    .clk(clk),
    .rst(rst),
    .lb(optics_lb.latch)
  );

  latch_byte #(.W(DATA_W), .IMPL_MASK(flag_bank_pkg::SUPPLY_MASK), .RESET_VAL(flag_bank_pkg::FLAG_RESET)) u_alarm (
    .clk(clk),
    .rst(rst),
    .lb(alarm_lb.latch)
  );

  latch_byte #(.W(DATA_W), .IMPL_MASK(flag_bank_pkg::SUPPLY_MASK), .RESET_VAL(flag_bank_pkg::FLAG_RESET)) u_warn (
    .clk(clk),
    .rst(rst),
    .lb(warn_lb.latch)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] rdata_r;

  // returns the value before the clear takes effect; unmapped reads give zero
  always_comb
  begin
    rdata_nxt = flag_bank_pkg::READ_IDLE;
    if (rd)
    begin
      case (addr)
        flag_bank_pkg::AUX_WARN_OFS: rdata_nxt = aux_lb.flags;
        flag_bank_pkg::LINK_STAT_OFS: rdata_nxt = link_lb.flags;
        flag_bank_pkg::OPTICS_FAULT_OFS: rdata_nxt = optics_lb.flags;
        flag_bank_pkg::SUPPLY_ALARM_OFS: rdata_nxt = alarm_lb.flags;
        flag_bank_pkg::SUPPLY_WARN_OFS: rdata_nxt = warn_lb.flags;
        flag_bank_pkg::LIVE_AUX_OFS: rdata_nxt = aux_live & flag_bank_pkg::AUX_WARN_MASK;
        flag_bank_pkg::LIVE_LINK_OFS: rdata_nxt = link_live;
        flag_bank_pkg::LIVE_OPTICS_OFS: rdata_nxt = optics_live & flag_bank_pkg::OPTICS_FAULT_MASK;
        flag_bank_pkg::LIVE_ALARM_OFS: rdata_nxt = alarm_live;
        flag_bank_pkg::LIVE_WARN_OFS: rdata_nxt = warn_live;
        flag_bank_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
        default: rdata_nxt = flag_bank_pkg::READ_IDLE;
      endcase
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= flag_bank_pkg::READ_IDLE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule

/* bench/flag_bank_sva.sv */
`timescale 1ns/100ps
module flag_bank_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic aux1_low_warn,
  input wire logic transmit_not_ready,
  input wire logic laser_fault,
  input wire logic receive_not_ready,
  input wire logic receive_signal_loss,
  input wire logic module_not_ready,
  input wire logic thermoelectric_cooler_fault,
  input wire logic plus_five_volt_rail_alarm_high,
  input wire logic negative_five_volt_rail_warn_low
);
  // ----------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // a source held across the sync delay must show in the read of its byte
  a_transmit_not_ready_latch: assert property (transmit_not_ready[*6] ##0 (rd && addr == 8'h54) |=> rdata[7])
    else $error("transmit not ready not latched");
  a_laser_latch: assert property (laser_fault[*6] ##0 (rd && addr == 8'h54) |=> rdata[6])
    else $error("laser fault not latched");
  a_rx_loss_latch: assert property (receive_signal_loss[*6] ##0 (rd && addr == 8'h54) |=> rdata[3])
    else $error("signal loss not latched");
  a_receive_not_ready_latch: assert property (receive_not_ready[*6] ##0 (rd && addr == 8'h54) |=> rdata[4])
    else $error("receive not ready not latched");
  a_module_not_ready_latch: assert property (module_not_ready[*6] ##0 (rd && addr == 8'h54) |=> rdata[1])
    else $error("module not ready not latched");
  a_cooler_latch: assert property (thermoelectric_cooler_fault[*6] ##0 (rd && addr == 8'h55) |=> rdata[6])
    else $error("cooler fault not latched");
  a_optics_reserved: assert property ($past(rd) && $past(addr) == 8'h55 |-> rdata[4:0] == 5'h00)
    else $error("reserved optics bits set");
  a_five_alarm: assert property (plus_five_volt_rail_alarm_high[*6] ##0 (rd && addr == 8'h56) |=> rdata[7])
    else $error("five volt alarm not latched");
  a_neg_warn: assert property (negative_five_volt_rail_warn_low[*6] ##0 (rd && addr == 8'h57) |=> rdata[0])
    else $error("negative rail warning not latched");
  a_aux_layout: assert property ($past(rd) && $past(addr) == 8'h53 |-> (rdata & 8'he7) == 8'h00)
    else $error("aux byte bit outside layout");
  a_aux1_latch: assert property (aux1_low_warn[*6] ##0 (rd && addr == 8'h53) |=> rdata[4])
    else $error("aux1 low warning not latched");
  // read data only stands in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");

  c_link_read: cover property (rd && addr == 8'h54 ##1 rdata != 8'h00);
  c_ctrl_write: cover property (wr && addr == 8'hf0);
  c_warn_read: cover property (rd && addr == 8'h57 ##1 rdata != 8'h00);
endmodule

/* bench/host_master.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host side of the management port: one-cycle strobes, no waits
// ----------------------------------------------------------------
module host_master (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // idle bus from time zero
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // data is taken 1 ns after the answer edge, clear of that edge's updates
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic write_byte(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
endmodule

/* bench/test_latched_module_flag_bank.sv */
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[ERR] %0t read %h expected %h", $time, got, exp); \
    end \
  end
module test_latched_module_flag_bank;
  logic clk;
  logic rst;
  logic [39:0] cond;
  logic [7:0] addr, wdata, rdata, d, a8, e;
  logic wr, rd;
  int failures = 0;
  int comparisons = 0;
  // implemented bits per byte, warn byte lowest; link bit0 has no input
  localparam logic [39:0] IMPL = {flag_bank_pkg::AUX_WARN_MASK, 8'hfe, flag_bank_pkg::OPTICS_FAULT_MASK,
    flag_bank_pkg::SUPPLY_MASK, flag_bank_pkg::SUPPLY_MASK};

  // ----------------------------------------------------------------
  // design and host; unconnected cond bits stand for reserved places
  // ----------------------------------------------------------------
  latched_module_flag_bank DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .aux1_low_warn(cond[36]), .aux2_high_warn(cond[35]),
    .transmit_not_ready(cond[31]), .laser_fault(cond[30]), .tx_cdr_unlock(cond[29]),
    .receive_not_ready(cond[28]), .receive_signal_loss(cond[27]), .rx_cdr_unlock(cond[26]),
    .module_not_ready(cond[25]), .avalanche_photodiode_fault(cond[23]),
    .thermoelectric_cooler_fault(cond[22]), .wavelength_unlocked(cond[21]),
    .plus_five_volt_rail_alarm_high(cond[15]), .plus_five_volt_rail_alarm_low(cond[14]),
    .three_volt_rail_alarm_high(cond[13]), .three_volt_rail_alarm_low(cond[12]),
    .one_eight_volt_rail_alarm_high(cond[11]), .one_eight_volt_rail_alarm_low(cond[10]),
    .negative_five_volt_rail_alarm_high(cond[9]), .negative_five_volt_rail_alarm_low(cond[8]),
    .plus_five_volt_rail_warn_high(cond[7]), .plus_five_volt_rail_warn_low(cond[6]),
    .three_volt_rail_warn_high(cond[5]), .three_volt_rail_warn_low(cond[4]),
    .one_eight_volt_rail_warn_high(cond[3]), .one_eight_volt_rail_warn_low(cond[2]),
    .negative_five_volt_rail_warn_high(cond[1]), .negative_five_volt_rail_warn_low(cond[0]));
  host_master host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // five cycles of reset, then room for the reset-complete pulse to land
  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cond = '0;
    do_reset();
    host.read_byte(8'h54, d); `CHK(d, 8'h01)
    host.read_byte(8'h54, d); `CHK(d, 8'h00)
    for (int k = 0; k < 5; k++)
    begin
      host.read_byte(8'h53 + 8'(k), d); `CHK(d, 8'h00)
    end
    $display("test reset values done");
    // walk every bit, reserved ones included, held, dropped, then read twice
    for (int i = 0; i < 40; i++)
    begin
      a8 = 8'h57 - 8'(i / 8);
      e = IMPL[(i / 8) * 8 +: 8] & (8'h01 << (i % 8));
      @(posedge clk) cond[i] <= 1'b1;
      repeat (6) @(posedge clk);
      host.read_byte(a8, d); `CHK(d, e)
      // live mirror shows the synchronised level with no latch in between
      host.read_byte(8'he4 - 8'(i / 8), d); `CHK(d, e)
      @(posedge clk) cond[i] <= 1'b0;
      repeat (5) @(posedge clk);
      host.read_byte(a8, d); `CHK(d, e)
      host.read_byte(a8, d); `CHK(d, 8'h00)
    end
    $display("test bit walk done");
    // clear-on-read off: flag survives reads until clear-all
    host.write_byte(8'hf0, 8'h00);
    host.read_byte(8'hf0, d); `CHK(d, 8'h00)
    host.write_byte(8'h55, 8'hff);
    @(posedge clk) cond[22] <= 1'b1;
    repeat (6) @(posedge clk);
    cond[22] <= 1'b0;
    repeat (5) @(posedge clk);
    host.read_byte(8'h55, d); `CHK(d, 8'h40)
    host.read_byte(8'h55, d); `CHK(d, 8'h40)
    host.write_byte(8'hf0, 8'h80);
    host.read_byte(8'hf0, d); `CHK(d, 8'h00)
    host.read_byte(8'h55, d); `CHK(d, 8'h00)
    host.write_byte(8'hf0, 8'h01);
    host.read_byte(8'hf0, d); `CHK(d, 8'h01)
    host.read_byte(8'h60, d); `CHK(d, 8'h00)
    $display("test clear control done");
    // second reset while a source stays high
    @(posedge clk) cond[31] <= 1'b1;
    do_reset();
    repeat (3) @(posedge clk);
    host.read_byte(8'h54, d); `CHK(d, 8'h81)
    @(posedge clk) cond[31] <= 1'b0;
    $display("test mid-run reset done");
    print_verdict();
  end

  // watchdog, far beyond the roughly 1000 cycles the tests need
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule

bind latched_module_flag_bank flag_bank_sva chk (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd),
  .rdata(rdata), .aux1_low_warn(aux1_low_warn), .transmit_not_ready(transmit_not_ready),
  .laser_fault(laser_fault), .receive_not_ready(receive_not_ready),
  .receive_signal_loss(receive_signal_loss), .module_not_ready(module_not_ready),
  .thermoelectric_cooler_fault(thermoelectric_cooler_fault),
  .plus_five_volt_rail_alarm_high(plus_five_volt_rail_alarm_high),
  .negative_five_volt_rail_warn_low(negative_five_volt_rail_warn_low));
